/* File: inc/decx_pkg.sv */
`default_nettype none
package decx_pkg;
    localparam int          WORD_W      = 14;
    localparam int          DATA_W      = 8;
    localparam int          IDX_W       = 7;
    localparam logic [1:0]  OP_TOP      = 2'h0;
    localparam logic [3:0]  OP_DEC      = 4'h3;
    localparam logic [3:0]  OP_DEC_SKIP = 4'hB;
    localparam int          TOP_MSB     = 13;
    localparam int          OP_MSB      = 11;
    localparam int          OP_LSB      = 8;
    localparam int          DEST_BIT    = 7;
    localparam logic        DEST_ACC    = 1'b0;
    localparam logic [7:0]  ONE         = 8'h01;
    localparam logic [7:0]  ACC_RESET   = 8'h00;
    localparam logic        ZERO_RESET  = 1'b0;

    typedef struct packed {
        logic             valid;
        logic [WORD_W-1:0] word;
    } decx_instr_t;

    typedef struct packed {
        logic             we;
        logic [IDX_W-1:0]  idx;
        logic [DATA_W-1:0] data;
    } decx_wr_t;

    typedef enum logic [1:0] {
        DECX_Q1,
        DECX_Q2,
        DECX_Q3,
        DECX_Q4
    } decx_phase_t;
endpackage
`default_nettype wire

/* File: hdl/decx_exec.sv */
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - seven-bit index, one destination bit
// - result is register minus one, zero flag set by the plain form only
// - decode 00 0011 d fffffff as decrement
// - d zero: accumulator gets result, register kept
// - skip variant stores count, skips on zero
// - d one: result written back to register
// - skip on zero costs a second nop cycle
module decx_exec (
    input  wire logic                       clock,
    input  wire logic                       reset,
    input  wire decx_pkg::decx_instr_t      instr,
    input  wire logic [decx_pkg::DATA_W-1:0] rd_data,
    output logic [decx_pkg::IDX_W-1:0]      rd_idx,
    output decx_pkg::decx_wr_t              wr,
    output logic [decx_pkg::DATA_W-1:0]     acc,
    output logic                            zero_flag,
    output logic                            skip_next,
    output logic                            busy,
    output logic                            done
);
    // phases stepped by this block; the fetch side may drop the instruction
    // once taken, since is_skip, dest and rd_idx latch it when sampled, at Q1 only
    decx_pkg::decx_phase_t phase;
    logic                  active;
    logic                  is_skip;
    logic                  dest;
    logic                  nop_cycle;
    logic [decx_pkg::DATA_W-1:0] result;

    wire logic       hit_top  = instr.word[decx_pkg::TOP_MSB -: 2]
                               == decx_pkg::OP_TOP;
    wire logic [3:0] op_field = instr.word[decx_pkg::OP_MSB:decx_pkg::OP_LSB];
    wire logic       hit_dec  = instr.valid && hit_top
                               && op_field == decx_pkg::OP_DEC;
    wire logic       hit_skip = instr.valid && hit_top
                               && op_field == decx_pkg::OP_DEC_SKIP;
    wire logic       start    = (hit_dec || hit_skip) && !active
                               && !nop_cycle;
    wire logic [decx_pkg::DATA_W-1:0] next_result =
                               rd_data - decx_pkg::ONE;
    wire logic       res_zero = (result == '0);
    wire logic       at_q4    = active && phase == decx_pkg::DECX_Q4;

    always_ff @(posedge clock) begin
        if (reset) begin
            phase     <= decx_pkg::DECX_Q1;
            active    <= 1'b0;
            nop_cycle <= 1'b0;
        end else begin
            if (start || active || nop_cycle) begin
                unique case (phase)
                    decx_pkg::DECX_Q1: phase <= decx_pkg::DECX_Q2;
                    decx_pkg::DECX_Q2: phase <= decx_pkg::DECX_Q3;
                    decx_pkg::DECX_Q3: phase <= decx_pkg::DECX_Q4;
                    decx_pkg::DECX_Q4: phase <= decx_pkg::DECX_Q1;
                endcase
            end
            if (start)
                active <= 1'b1;
            else if (at_q4)
                active <= 1'b0;
            if (at_q4 && is_skip && res_zero)
                nop_cycle <= 1'b1;
            else if (nop_cycle && phase == decx_pkg::DECX_Q4)
                nop_cycle <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            is_skip <= 1'b0;
            dest    <= decx_pkg::DEST_ACC;
            rd_idx  <= '0;
            result  <= '0;
        end else begin
            if (start) begin
                is_skip <= hit_skip;
                dest    <= instr.word[decx_pkg::DEST_BIT];
                rd_idx  <= instr.word[decx_pkg::IDX_W-1:0];
            end
            if (active && phase == decx_pkg::DECX_Q3)
                result <= next_result;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            wr        <= '0;
            acc       <= decx_pkg::ACC_RESET;
            zero_flag <= decx_pkg::ZERO_RESET;
            skip_next <= 1'b0;
            done      <= 1'b0;
        end else begin
            wr.we     <= at_q4 && dest != decx_pkg::DEST_ACC;
            wr.idx    <= rd_idx;
            wr.data   <= result;
            if (at_q4 && dest == decx_pkg::DEST_ACC)
                acc <= result;
            if (at_q4 && !is_skip)
                zero_flag <= res_zero;
            skip_next <= at_q4 && is_skip && res_zero;
            done      <= at_q4;
        end
    end

    always_ff @(posedge clock) begin
        if (reset)
            busy <= 1'b0;
        else
            busy <= start || (active && !at_q4) || (at_q4 && is_skip && res_zero)
                    || (nop_cycle && phase != decx_pkg::DECX_Q4);
    end

    // helper: cycle counter of the nop cycle
    logic [2:0] nop_len;
    always_ff @(posedge clock) begin
        if (reset)
            nop_len <= '0;
        else if (nop_cycle)
            nop_len <= nop_len + 3'h1;
        else
            nop_len <= '0;
    end

    // checks sit beside the logic; all sampled on the one clock
    // reset masks them so the flush cycle cannot misfire

    AST_DECODE_START: assert property (
        @(posedge clock) disable iff (reset)
        start |=> active && phase == decx_pkg::DECX_Q2)
        else $error("decrement not taken");

    AST_FOUR_PHASES: assert property (
        @(posedge clock) disable iff (reset)
        start |=> active [*3] ##1 !active)
        else $error("instruction not four phases");

    AST_RESULT: assert property (
        @(posedge clock) disable iff (reset)
        active && phase == decx_pkg::DECX_Q3
        |=> result == $past(rd_data) - decx_pkg::ONE)
        else $error("result not minus one");

    AST_ACC_DEST: assert property (
        @(posedge clock) disable iff (reset)
        at_q4 && dest == decx_pkg::DEST_ACC
        |=> acc == $past(result) && !wr.we)
        else $error("accumulator destination wrong");

    AST_REG_DEST: assert property (
        @(posedge clock) disable iff (reset)
        at_q4 && dest != decx_pkg::DEST_ACC
        |=> wr.we && wr.data == $past(result) && $stable(acc))
        else $error("register destination wrong");

    AST_ZERO_FLAG: assert property (
        @(posedge clock) disable iff (reset)
        at_q4 && !is_skip |=> zero_flag == (wr.data == 8'h00))
        else $error("zero flag wrong");

    AST_SKIP: assert property (
        @(posedge clock) disable iff (reset)
        at_q4 && is_skip |=> skip_next == (wr.data == 8'h00))
        else $error("skip decision wrong");

    AST_NOP_LEN: assert property (
        @(posedge clock) disable iff (reset)
        nop_cycle |-> nop_len < 3'h4)
        else $error("nop cycle too long");

    AST_NOP_BUSY: assert property (
        @(posedge clock) disable iff (reset)
        skip_next |-> busy ##1 busy ##1 busy)
        else $error("nop cycle not held busy");

    AST_IDX: assert property (
        @(posedge clock) disable iff (reset)
        start |=> rd_idx == $past(instr.word[6:0]))
        else $error("index not latched");

    AST_SKIP_KEEPS_ZERO: assert property (
        @(posedge clock) disable iff (reset)
        at_q4 && is_skip |=> $stable(zero_flag))
        else $error("skip variant touched zero flag");

    AST_SKIP_ACC_DEST: assert property (
        @(posedge clock) disable iff (reset)
        at_q4 && is_skip && dest == decx_pkg::DEST_ACC
        |=> !wr.we && acc == $past(result))
        else $error("skip count not in accumulator");

    AST_DONE_IDLE: assert property (
        @(posedge clock) disable iff (reset)
        done && !skip_next |-> !busy)
        else $error("busy after single cycle instruction");

    AST_DONE_PULSE: assert property (
        @(posedge clock) disable iff (reset)
        done |=> !done)
        else $error("done longer than one cycle");

    AST_NOP_NO_DONE: assert property (
        @(posedge clock) disable iff (reset)
        skip_next |=> !done [*4])
        else $error("nop cycle finished an instruction");

    COV_DEC_ACC: cover property (@(posedge clock) disable iff (reset)
        at_q4 && !is_skip && dest == decx_pkg::DEST_ACC);

    COV_DEC_REG: cover property (@(posedge clock) disable iff (reset)
        at_q4 && !is_skip && dest != decx_pkg::DEST_ACC);

    COV_SKIP_TAKEN: cover property (@(posedge clock) disable iff (reset)
        skip_next);

    COV_SKIP_NOT: cover property (@(posedge clock) disable iff (reset)
        at_q4 && is_skip && !res_zero);

    COV_NEXT_TAKEN: cover property (@(posedge clock) disable iff (reset)
        done ##2 start);
endmodule
`default_nettype wire

/* File: verif/decrement_instruction_exec_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module decrement_instruction_exec_bench;
    logic                   clock;
    logic                   reset;
    decx_pkg::decx_instr_t  instr;
    logic [7:0]             rd_data;
    logic [6:0]             rd_idx;
    decx_pkg::decx_wr_t     wr;
    logic [7:0]             acc;
    logic                   zero_flag;
    logic                   skip_next;
    logic                   busy;
    logic                   done;
    int                     fails;
    int                     n_compared;
    int                     cycles;

    decx_exec i_dut (
        .clock(clock), .reset(reset), .instr(instr), .rd_data(rd_data),
        .rd_idx(rd_idx), .wr(wr), .acc(acc), .zero_flag(zero_flag),
        .skip_next(skip_next), .busy(busy), .done(done)
    );

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic check(input string name, input logic [15:0] exp,
                         input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // valid dropped right after the taking edge so the word is taken once
    task automatic issue(input logic [3:0] op, input logic d,
                         input logic [6:0] idx, input logic [7:0] val);
        @(posedge clock);
        instr <= {1'b1, decx_pkg::OP_TOP, op, d, idx};
        rd_data <= val;
        @(posedge clock);
        instr.valid <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
    endtask

    task automatic t_plain_reg;
        issue(decx_pkg::OP_DEC, 1'b1, 7'h00, 8'h00);
        check("done", 16'h0001, 16'(done));
        check("wr", {1'b1, 7'h00, 8'hFF}, wr);
        check("acc", 16'h0000, 16'(acc));
        check("zero", 16'h0000, 16'(zero_flag));
    endtask

    task automatic t_plain_acc;
        issue(decx_pkg::OP_DEC, 1'b0, 7'h7F, 8'h01);
        check("rd_idx", 16'h007F, 16'(rd_idx));
        check("acc", 16'h0000, 16'(acc));
        check("we", 16'h0000, 16'(wr.we));
        check("zero", 16'h0001, 16'(zero_flag));
        check("busy", 16'h0000, 16'(busy));
        check("skip", 16'h0000, 16'(skip_next));
    endtask

    task automatic t_skip_zero;
        issue(decx_pkg::OP_DEC_SKIP, 1'b1, 7'h55, 8'h01);
        check("wr", {1'b1, 7'h55, 8'h00}, wr);
        check("skip", 16'h0001, 16'(skip_next));
        check("zero", 16'h0001, 16'(zero_flag));
        repeat (3) @(posedge clock);
        #1;
        check("busy", 16'h0001, 16'(busy));
        @(posedge clock);
        #1;
        check("busy", 16'h0000, 16'(busy));
    endtask

    task automatic t_skip_live;
        issue(decx_pkg::OP_DEC_SKIP, 1'b0, 7'h03, 8'h05);
        check("acc", 16'h0004, 16'(acc));
        check("skip", 16'h0000, 16'(skip_next));
        check("busy", 16'h0000, 16'(busy));
    endtask

    task automatic t_refuse;
        issue(4'hA, 1'b1, 7'h09, 8'h10);
        check("done", 16'h0000, 16'(done));
        check("we", 16'h0000, 16'(wr.we));
        check("acc", 16'h0004, 16'(acc));
    endtask

    // ceiling well above the forty or so cycles the tasks need
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fails++;
            stop_test;
        end
    end

    initial begin
        reset = 1'b1;
        instr = '0;
        rd_data = 8'h00;
        fails = 0;
        n_compared = 0;
        cycles = 0;
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        #1;
        check("acc", 16'h0000, 16'(acc));
        t_plain_reg();
        t_plain_acc();
        t_skip_zero();
        t_skip_live();
        t_refuse();
        stop_test;
    end
endmodule
`default_nettype wire
